// file: test/tb_xps_host.sv
// Self-checking bench for the crosspoint switch host controller
`timescale 1ns/100ps
module tb_xps_host;
  import xps_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wide = 1'b1, snap = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r2, w, prev = 32'h0000_0000;
  logic pready, pslverr, sps, a2, a1, a0, c3, c2, d1_out, d1_oe, d0, wr, lt, els, ce_n, ce, so;
  logic [7:0] en, e_en = 8'h00;
  logic [3:0] e_r1 [8], e_r2 [8];
  logic [40:0] exp_q [$];
  int err_count = 0, n_tests = 0, seed_dummy;
  // Released pin shows the serial output while serial is selected, else the inverse of the last drive so a stale value never passes
  wire d1_pin = d1_oe ? d1_out : (sps ? so : ~d1_out);

  always #12.5 ref_clk = ~ref_clk;

  xps_host xps_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_parallel_select(sps), .output_select_bit2(a2), .output_select_bit1(a1), .output_select_bit0(a0),
    .code_bit3(c3), .code_bit2(c2), .code_bit1_serial_out_in(d1_pin), .code_bit1_serial_out_out(d1_out),
    .code_bit1_serial_out_oe(d1_oe), .code_bit0_serial_in(d0), .write_strobe(wr), .latch_strobe(lt),
    .edge_level_select(els), .chip_enable_n(ce_n), .chip_enable(ce));
  xps_dev_model xps_dev_model_inst (.ser_sel(sps), .sel({a2, a1, a0}), .code({c3, c2, d1_pin, d0}), .ser_in(d0),
    .wr(wr), .latch(lt), .edge_sel(els), .ce_n(ce_n), .ce(ce), .wide(wide), .ser_out(so), .rank2_flat(r2),
    .buf_en(en));

  task automatic final_report();
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    logic [40:0] got, ex;
    if ((psel && penable && pready && !pwrite) || snap) begin
      got = snap ? {1'b0, r2, en} : {8'h00, pslverr, prdata};
      ex = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      n_tests++;
      if (got !== ex) begin
        err_count++;
        $display("unexpected %s: expected %h, seen %h", snap ? "switch_state" : "prdata", ex, got);
      end
    end
  end

  task automatic apb(input logic [7:0] a, input logic wn, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wn;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back({8'h00, e});
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  task automatic wait_idle();
    int t = 0, q = 0;
    while (q < 8 && t < 5000) begin
      @(posedge ref_clk);
      t++;
      // A latch-only job never enables the chip, so both strobes must rest high as well
      q = (ce_n === 1'b1 && ce === 1'b0 && lt === 1'b1 && wr === 1'b1) ? q + 1 : 0;
    end
    if (q < 8) begin
      err_count++;
      $display("unexpected idle: expected 8, seen %0d", q);
    end
  endtask

  task automatic snapshot();
    logic [31:0] f;
    foreach (e_r2[k]) f[4*k +: 4] = e_r2[k];
    exp_q.push_back({1'b0, f, e_en});
    snap <= 1'b1;
    @(posedge ref_clk);
    snap <= 1'b0;
  endtask

  task automatic e_xfer();
    for (int k = 0; k < 8; k++) begin
      e_r2[k] = e_r1[k];
      if (e_r1[k] == 4'h9) e_en[k] = 1'b1;
      if (e_r1[k] == 4'hA) e_en[k] = 1'b0;
    end
  endtask

  // A refused word must leave the switch untouched, so its expectation is not updated
  task automatic par(input logic [2:0] s, input logic [3:0] c, input logic lat, input logic bad);
    if (!bad) begin
      if (!c[3] || c == 4'h8) e_r1[s] = c;
      else begin
        e_xfer();
        if (c == 4'hB) e_en[s] = 1'b0;
        if (c == 4'hC) e_en[s] = 1'b1;
        if (c == 4'hD) e_en = 8'h00;
        if (c == 4'hE) e_en = 8'hFF;
      end
      if (lat) e_xfer();
    end
    apb(ADDR_CMD, 1'b1, {23'h0, lat, 1'b0, s, c});
    wait_idle();
    snapshot();
  endtask

  task automatic ser(input logic [31:0] d, input int n);
    for (int k = 0; k < n; k++) e_r1[k] = d[4*k +: 4];
    e_xfer();
    apb(ADDR_SERIAL, 1'b1, d);
    wait_idle();
    snapshot();
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    $display("unexpected timeout: expected done, seen running");
    final_report();
  end

  initial begin
    seed_dummy = $urandom(32'hDE583E55);
    foreach (e_r1[k]) e_r1[k] = 4'h0;
    foreach (e_r2[k]) e_r2[k] = 4'h0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, {29'h0, CTRL_RESET});
    rd(ADDR_STATUS, 33'h0);
    rd(8'h18, {1'b1, 32'h0});
    snapshot();
    for (int k = 0; k < 8; k++) par(k[2:0], 4'($urandom_range(7)), 1'b0, 1'b0);
    e_xfer();
    apb(ADDR_LATCH, 1'b1, 32'h0000_0001);
    wait_idle();
    snapshot();
    par(3'h0, 4'hE, 1'b0, 1'b0);
    par(3'h3, 4'hB, 1'b0, 1'b0);
    par(3'h3, 4'hC, 1'b0, 1'b0);
    par(3'h5, 4'h8, 1'b1, 1'b0);
    par(3'h1, 4'h6, 1'b0, 1'b0);
    par(3'h0, 4'hF, 1'b0, 1'b0);
    par(3'h6, 4'hD, 1'b0, 1'b0);
    par(3'h2, 4'h9, 1'b1, 1'b1);
    rd(ADDR_STATUS, 33'h2);
    apb(ADDR_STATUS, 1'b1, 32'h0000_0002);
    apb(ADDR_CTRL, 1'b1, 32'h0000_000E);
    par(3'h1, 4'h5, 1'b1, 1'b1);
    rd(ADDR_STATUS, 33'h2);
    apb(ADDR_STATUS, 1'b1, 32'h0000_0002);
    rd(ADDR_STATUS, 33'h0);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0004);
    par(3'h7, 4'($urandom_range(7)), 1'b1, 1'b0);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0007);
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 8; k++) w[4*k +: 4] = 4'($urandom_range(10));
      if (j == 0) w[7:0] = 8'hA9;
      ser(w, 8);
      rd(ADDR_READBACK, {1'b0, prev[30:0], w[3]});
      for (int k = 0; k < 8; k++) prev[31-4*k -: 4] = w[4*k +: 4];
    end
    wide <= 1'b0;
    apb(ADDR_CTRL, 1'b1, 32'h0000_0003);
    ser({16'h0000, 4'h9, 4'($urandom_range(3)), 4'hA, 4'h8}, 4);
    final_report();
  end
endmodule // tb_xps_host

// file: test/xps_dev_model.sv
// Behavioural model of the crosspoint switch digital interface
`timescale 1ns/100ps
module xps_dev_model (
  input wire logic ser_sel, // High for serial loading
  input wire logic [2:0] sel, // Output address
  input wire logic [3:0] code, // Code bits as seen on the pins
  input wire logic ser_in, // Serial data in
  input wire logic wr, // Write strobe
  input wire logic latch, // Transfer strobe
  input wire logic edge_sel, // High for edge latching
  input wire logic ce_n, // Chip enable, active low
  input wire logic ce, // Chip enable, active high
  input wire logic wide, // High for the eight-output variant
  output logic ser_out, // End of the shift chain
  output logic [31:0] rank2_flat, // Second rank, output k at nibble k
  output logic [7:0] buf_en // Buffer enables
);
  logic [3:0] r1 [8];
  logic [31:0] chain;

  // Routing is not preset at power-up; zero is only a model convenience
  initial begin
    foreach (r1[k]) r1[k] = 4'h0;
    chain = 32'h0000_0000;
    rank2_flat = 32'h0000_0000;
    buf_en = 8'h00;
  end

  task automatic xfer();
    for (int k = 0; k < 8; k++) begin
      rank2_flat[4*k +: 4] = r1[k];
      if (r1[k] == 4'h9) buf_en[k] = 1'b1;
      if (r1[k] == 4'hA) buf_en[k] = 1'b0;
    end
  endtask

  assign ser_out = wide ? chain[31] : chain[15];

  // Gating on the strobe edge, not on the AND, so enabling the chip never fakes an edge
  always @(posedge wr) begin
    if (ce && !ce_n) begin
      if (ser_sel) begin
        chain = {chain[30:0], ser_in};
        for (int k = 0; k < (wide ? 8 : 4); k++) r1[k] = chain[(wide ? 31 : 15) - 4 * k -: 4];
      end else if (!code[3] || code == 4'h8) begin
        r1[sel] = code;
      end else if (code != 4'hF || latch) begin
        xfer();
        if (code == 4'hB) buf_en[sel] = 1'b0;
        if (code == 4'hC) buf_en[sel] = 1'b1;
        if (code == 4'hD) buf_en = 8'h00;
        if (code == 4'hE) buf_en = 8'hFF;
      end
    end
  end

  always @(posedge latch) if (edge_sel) xfer();
  always @(negedge latch) if (!edge_sel) xfer();
endmodule // xps_dev_model

// file: verilog/xps_apb_regs.sv
// APB register slave of the crosspoint switch host controller
`timescale 1ns/100ps
module xps_apb_regs
  import xps_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  xps_ctl_if.regs ctl // To the sequencer
);
  logic reject_flag;
  logic mapped;
  logic start_addr;
  logic busy_any;
  logic wr_done;

  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_CMD) || (paddr == ADDR_SERIAL) ||
                  (paddr == ADDR_LATCH) || (paddr == ADDR_STATUS) || (paddr == ADDR_READBACK);
  assign start_addr = (paddr == ADDR_CMD) || (paddr == ADDR_SERIAL) || (paddr == ADDR_LATCH);
  // A start pulse still in flight counts as busy so no second job slips in
  assign busy_any = ctl.busy || ctl.start_cmd || ctl.start_ser || ctl.start_latch;
  assign wr_done = psel && penable && pready && pwrite && !pslverr;

  // One wait-free access phase: answer prepared in the setup cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (!mapped || (pwrite && start_addr && busy_any));
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata <= {{(32-CTRL_W){1'b0}}, ctl.ctrl};
          ADDR_CMD: prdata <= {{(32-CMD_W){1'b0}}, ctl.cmd_word};
          ADDR_SERIAL: prdata <= ctl.ser_data;
          ADDR_STATUS: prdata <= {30'h0000_0000, reject_flag, ctl.busy};
          ADDR_READBACK: prdata <= ctl.readback;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl.ctrl <= CTRL_RESET;
      ctl.cmd_word <= '0;
      ctl.ser_data <= '0;
      ctl.start_cmd <= 1'b0;
      ctl.start_ser <= 1'b0;
      ctl.start_latch <= 1'b0;
    end else begin
      ctl.start_cmd <= wr_done && (paddr == ADDR_CMD);
      ctl.start_ser <= wr_done && (paddr == ADDR_SERIAL);
      ctl.start_latch <= wr_done && (paddr == ADDR_LATCH);
      if (wr_done && paddr == ADDR_CTRL) ctl.ctrl <= pwdata[CTRL_W-1:0];
      if (wr_done && paddr == ADDR_CMD) ctl.cmd_word <= pwdata[CMD_W-1:0];
      if (wr_done && paddr == ADDR_SERIAL) ctl.ser_data <= pwdata;
    end
  end

  // Set from the sequencer wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reject_flag <= 1'b0;
    end else if (ctl.reject) begin
      reject_flag <= 1'b1;
    end else if (wr_done && paddr == ADDR_STATUS && pwdata[STAT_REJECT_BIT]) begin
      reject_flag <= 1'b0;
    end
  end
endmodule // xps_apb_regs

// file: verilog/xps_ctl_if.sv
// Carrier between the register slave and the pin sequencer
`timescale 1ns/100ps
interface xps_ctl_if;
  logic [xps_pkg::CTRL_W-1:0] ctrl;
  logic start_cmd;
  logic start_ser;
  logic start_latch;
  logic [xps_pkg::CMD_W-1:0] cmd_word;
  logic [xps_pkg::DATA_W-1:0] ser_data;
  logic busy;
  logic reject;
  logic [xps_pkg::DATA_W-1:0] readback;
  modport regs (output ctrl, start_cmd, start_ser, start_latch, cmd_word, ser_data,
                input busy, reject, readback);
  modport core (input ctrl, start_cmd, start_ser, start_latch, cmd_word, ser_data,
                output busy, reject, readback);
endinterface

// file: verilog/xps_host.sv
// Host controller that loads a video crosspoint switch through its parallel or serial pins
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Behaviour
// - Four outputs: two select bits plus code
// - Eight outputs: three select bits plus code
// - Host never sends 1001/1010 in parallel
// - Four outputs: sixteen serial bits, output0 first
// - Eight outputs: thirty-two serial bits, output0 first
// - Serial codes limited to 0000-1010 range
// - Host never sends 1011-1111 in serial
module xps_host
  import xps_pkg::*;
(
  input wire logic ref_clk, // 40 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic serial_parallel_select, // High for serial loading
  output logic output_select_bit2, // Output address bit 2
  output logic output_select_bit1, // Output address bit 1
  output logic output_select_bit0, // Output address bit 0
  output logic code_bit3, // Code bit 3
  output logic code_bit2, // Code bit 2
  input wire logic code_bit1_serial_out_in, // Pin level, serial output in serial mode
  output logic code_bit1_serial_out_out, // Code bit 1 drive value
  output logic code_bit1_serial_out_oe, // High while driving code bit 1
  output logic code_bit0_serial_in, // Code bit 0 or serial data
  output logic write_strobe, // Write strobe, captured on rise
  output logic latch_strobe, // Transfer strobe, idles high
  output logic edge_level_select, // High for edge latching
  output logic chip_enable_n, // Chip enable, active low
  output logic chip_enable // Chip enable, active high
);
  typedef enum logic [2:0] {
    XPS_IDLE, XPS_SETUP, XPS_WR_LOW, XPS_WR_HIGH, XPS_LATCH_LOW, XPS_LATCH_HIGH
  } xps_state_type;

  xps_ctl_if ctl ();
  xps_state_type state;
  logic [CNT_W-1:0] cnt;
  logic [5:0] bit_cnt;
  logic [5:0] bits_total;
  logic job_serial;
  logic job_latch;
  logic [CODE_W-1:0] job_code;
  logic [SEL_W-1:0] job_sel;
  logic [DATA_W-1:0] job_data;
  logic serial_sync1;
  logic serial_sync2;
  logic [DATA_W-1:0] readback;
  logic wide;
  logic narrow_in;
  logic next_bit;
  logic [4:0] bit_pos;

  xps_apb_regs u_regs (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctl(ctl.regs)
  );

  assign wide = ctl.ctrl[CTRL_WIDE_BIT];
  assign narrow_in = ctl.ctrl[CTRL_NARROW_IN_BIT];
  // Output 0 first, and within each code bit 3 first
  assign bit_pos = {bit_cnt[4:2], 2'b11 - bit_cnt[1:0]};
  assign next_bit = job_data[bit_pos];
  assign ctl.readback = readback;

  function automatic logic serial_word_ok(input logic [DATA_W-1:0] data, input logic wide_sel,
                                          input logic narrow);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < OUTS_WIDE; k++) begin
      if ((wide_sel || k < OUTS_NARROW) && !code_ok_serial(data[4*k +: CODE_W], narrow)) ok = 1'b0;
    end
    serial_word_ok = ok;
  endfunction

  // The device drives code bit 1 asynchronously in serial mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_sync1 <= 1'b0;
      serial_sync2 <= 1'b0;
    end else begin
      serial_sync1 <= code_bit1_serial_out_in;
      serial_sync2 <= serial_sync1;
    end
  end

  // Sampled at the end of each write-high hold, after the device has shifted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readback <= '0;
    end else if (state == XPS_WR_HIGH && cnt == '0 && job_serial) begin
      readback <= {readback[DATA_W-2:0], serial_sync2};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= XPS_IDLE;
      cnt <= '0;
      bit_cnt <= '0;
      bits_total <= '0;
      job_serial <= 1'b0;
      job_latch <= 1'b0;
      job_code <= '0;
      job_sel <= '0;
      job_data <= '0;
      ctl.busy <= 1'b0;
      ctl.reject <= 1'b0;
      serial_parallel_select <= 1'b0;
      output_select_bit2 <= 1'b0;
      output_select_bit1 <= 1'b0;
      output_select_bit0 <= 1'b0;
      code_bit3 <= 1'b0;
      code_bit2 <= 1'b0;
      code_bit1_serial_out_out <= 1'b0;
      code_bit1_serial_out_oe <= 1'b1;
      code_bit0_serial_in <= 1'b0;
      write_strobe <= 1'b1;
      latch_strobe <= 1'b1;
      edge_level_select <= 1'b1;
      chip_enable_n <= 1'b1;
      chip_enable <= 1'b0;
    end else begin
      ctl.reject <= 1'b0;
      case (state)
        XPS_IDLE: begin
          ctl.busy <= 1'b0;
          chip_enable_n <= 1'b1;
          chip_enable <= 1'b0;
          edge_level_select <= ctl.ctrl[CTRL_EDGE_BIT];
          serial_parallel_select <= ctl.ctrl[CTRL_SERIAL_BIT];
          code_bit1_serial_out_oe <= !ctl.ctrl[CTRL_SERIAL_BIT];
          if (ctl.start_cmd) begin
            // Narrow parts have no output select bit 2
            if (!code_ok_parallel(ctl.cmd_word[CMD_CODE_LSB +: CODE_W], narrow_in) ||
                (!wide && ctl.cmd_word[CMD_SEL_LSB + SEL_W - 1])) begin
              ctl.reject <= 1'b1;
            end else begin
              job_serial <= 1'b0;
              job_code <= ctl.cmd_word[CMD_CODE_LSB +: CODE_W];
              job_sel <= ctl.cmd_word[CMD_SEL_LSB +: SEL_W];
              job_latch <= ctl.cmd_word[CMD_LATCH_BIT];
              ctl.busy <= 1'b1;
              state <= XPS_SETUP;
              cnt <= CNT_W'(SETUP_CYCLES - 1);
              serial_parallel_select <= 1'b0;
              code_bit1_serial_out_oe <= 1'b1;
              chip_enable_n <= 1'b0;
              chip_enable <= 1'b1;
              output_select_bit2 <= ctl.cmd_word[CMD_SEL_LSB + 2];
              output_select_bit1 <= ctl.cmd_word[CMD_SEL_LSB + 1];
              output_select_bit0 <= ctl.cmd_word[CMD_SEL_LSB];
              {code_bit3, code_bit2, code_bit1_serial_out_out, code_bit0_serial_in} <=
                ctl.cmd_word[CMD_CODE_LSB +: CODE_W];
            end
          end else if (ctl.start_ser) begin
            if (!serial_word_ok(ctl.ser_data, wide, narrow_in)) begin
              ctl.reject <= 1'b1;
            end else begin
              job_serial <= 1'b1;
              job_latch <= 1'b1;
              job_data <= ctl.ser_data;
              bit_cnt <= '0;
              bits_total <= wide ? 6'(BITS_WIDE) : 6'(BITS_NARROW);
              ctl.busy <= 1'b1;
              state <= XPS_SETUP;
              cnt <= CNT_W'(SETUP_CYCLES - 1);
              serial_parallel_select <= 1'b1;
              code_bit1_serial_out_oe <= 1'b0;
              chip_enable_n <= 1'b0;
              chip_enable <= 1'b1;
              {output_select_bit2, output_select_bit1, output_select_bit0} <= 3'h0;
              {code_bit3, code_bit2, code_bit1_serial_out_out} <= 3'h0;
              code_bit0_serial_in <= ctl.ser_data[DATA_W/8 - 1];
            end
          end else if (ctl.start_latch) begin
            job_serial <= 1'b0;
            ctl.busy <= 1'b1;
            state <= XPS_LATCH_LOW;
            cnt <= CNT_W'(STROBE_CYCLES - 1);
            latch_strobe <= 1'b0;
          end
        end
        XPS_SETUP: begin
          if (cnt == '0) begin
            state <= XPS_WR_LOW;
            cnt <= CNT_W'(STROBE_CYCLES - 1);
            write_strobe <= 1'b0;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        XPS_WR_LOW: begin
          if (cnt == '0) begin
            state <= XPS_WR_HIGH;
            cnt <= CNT_W'(HOLD_CYCLES - 1);
            write_strobe <= 1'b1;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        XPS_WR_HIGH: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (job_serial && bit_cnt != bits_total - 1'b1) begin
            bit_cnt <= bit_cnt + 1'b1;
            state <= XPS_SETUP;
            cnt <= CNT_W'(SETUP_CYCLES - 1);
            code_bit0_serial_in <= job_data[{bit_cnt[4:2] + 3'(bit_cnt[1:0] == 2'b11), 2'b10 - bit_cnt[1:0]}];
          end else if (job_latch) begin
            state <= XPS_LATCH_LOW;
            cnt <= CNT_W'(STROBE_CYCLES - 1);
            latch_strobe <= 1'b0;
          end else begin
            state <= XPS_IDLE;
          end
        end
        XPS_LATCH_LOW: begin
          if (cnt == '0) begin
            state <= XPS_LATCH_HIGH;
            cnt <= CNT_W'(HOLD_CYCLES - 1);
            latch_strobe <= 1'b1;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        XPS_LATCH_HIGH: begin
          if (cnt == '0) begin
            state <= XPS_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: state <= XPS_IDLE;
      endcase
    end
  end

  // Helper: write rises counted inside the current serial job
  logic [6:0] rise_cnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= '0;
    end else if (state == XPS_IDLE) begin
      rise_cnt <= '0;
    end else if (state == XPS_WR_LOW && cnt == '0) begin
      rise_cnt <= rise_cnt + 1'b1;
    end
  end

  sequence wr_pulse_seq;
    !write_strobe [*4] ##1 write_strobe;
  endsequence

  sequence latch_pulse_seq;
    !latch_strobe [*4] ##1 latch_strobe;
  endsequence

  chk_wr_enable_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !write_strobe |-> !chip_enable_n && chip_enable)
    else $error("write strobe low without both chip enables");

  chk_wr_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(write_strobe) |-> wr_pulse_seq)
    else $error("write strobe low time wrong");

  chk_word_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !write_strobe && !$past(write_strobe) |->
      $stable({output_select_bit2, output_select_bit1, output_select_bit0, code_bit3, code_bit2,
               code_bit1_serial_out_out, code_bit0_serial_in, serial_parallel_select}))
    else $error("pins moved while write strobe low");

  chk_parallel_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(write_strobe) && !serial_parallel_select |->
      code_ok_parallel({code_bit3, code_bit2, code_bit1_serial_out_out, code_bit0_serial_in}, narrow_in))
    else $error("serial-only code sent in parallel mode");

  chk_serial_codes: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == XPS_SETUP && job_serial |-> serial_word_ok(job_data, wide, narrow_in))
    else $error("illegal serial code shifted");

  chk_serial_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(latch_strobe) && job_serial |-> rise_cnt == 7'(bits_total))
    else $error("serial shift count wrong before latch");

  chk_latch_after: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == XPS_WR_HIGH && cnt == '0 && job_serial && bit_cnt == bits_total - 1'b1 |->
      ##1 latch_pulse_seq)
    else $error("no latch pulse after serial shift");

  chk_soft_latch_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(write_strobe) && !serial_parallel_select && {code_bit3, code_bit2} == 2'b11 |-> latch_strobe)
    else $error("control code written with latch low");

  chk_reject_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctl.reject |-> state == XPS_IDLE && write_strobe [*3])
    else $error("rejected job touched the pins");

  chk_serial_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == XPS_WR_LOW && job_serial |-> code_bit0_serial_in == next_bit)
    else $error("serial bit out of chain order");
endmodule // xps_host

// file: verilog/xps_pkg.sv
// Constants, register map and code checks for the crosspoint switch host controller
package xps_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETUP_TIME_NS = 50;
  localparam int STROBE_TIME_NS = 100;
  localparam int HOLD_TIME_NS = 100;
  localparam int SETUP_CYCLES = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  localparam int CODE_W = 4;
  localparam int SEL_W = 3;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 4;
  localparam int CMD_W = 9;
  localparam int BITS_NARROW = 16;
  localparam int BITS_WIDE = 32;
  localparam int OUTS_NARROW = 4;
  localparam int OUTS_WIDE = 8;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_SERIAL = 8'h08;
  localparam logic [7:0] ADDR_LATCH = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_READBACK = 8'h14;

  localparam int CTRL_SERIAL_BIT = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int CTRL_WIDE_BIT = 2;
  localparam int CTRL_NARROW_IN_BIT = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h6;
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_SEL_LSB = 4;
  localparam int CMD_LATCH_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REJECT_BIT = 1;

  localparam logic [CODE_W-1:0] CODE_LAST_NARROW = 4'h3;
  localparam logic [CODE_W-1:0] CODE_LAST_CHANNEL = 4'h7;
  localparam logic [CODE_W-1:0] CODE_GROUND = 4'h8;
  localparam logic [CODE_W-1:0] CODE_SER_ON = 4'h9;
  localparam logic [CODE_W-1:0] CODE_SER_OFF = 4'hA;
  localparam logic [CODE_W-1:0] CODE_SOFT_LATCH = 4'hF;

  // Parallel codes: 1001 and 1010 are serial-only, narrow inputs lose 0100..0111
  function automatic logic code_ok_parallel(input logic [CODE_W-1:0] code, input logic narrow);
    code_ok_parallel = (code != CODE_SER_ON) && (code != CODE_SER_OFF) &&
                       !(narrow && code > CODE_LAST_NARROW && code <= CODE_LAST_CHANNEL);
  endfunction

  // Serial codes: only 0000..1010, narrow inputs lose 0100..0111
  function automatic logic code_ok_serial(input logic [CODE_W-1:0] code, input logic narrow);
    code_ok_serial = (code <= CODE_SER_OFF) &&
                     !(narrow && code > CODE_LAST_NARROW && code <= CODE_LAST_CHANNEL);
  endfunction
endpackage
